// File: verilog/tpp_in_pkg.sv
// Constants, register map and carrier types for the transport packet parser input
`default_nettype none
package parser_pkg;

  // ---------------------------------------------------------------------------
  // Packet geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned PKT_LEN   = 188;
  localparam logic [7:0]  POS_LAST  = 8'(PKT_LEN - 1);
  localparam logic [7:0]  IDX_ERR   = 8'h02;  // third header byte
  localparam logic [7:0]  IDX_DEC   = 8'h03;  // last header byte, decision point
  localparam logic [7:0]  IDX_ALEN  = 8'h04;  // adaptation field length
  localparam logic [7:0]  IDX_AFLG  = 8'h05;  // adaptation flags
  localparam logic [7:0]  IDX_PES0  = 8'h04;  // first PES start code byte
  localparam logic [7:0]  IDX_PES2  = 8'h06;  // last PES start code byte
  localparam logic [7:0]  IDX_PSCR  = 8'h0A;  // PES flags byte with scrambling control
  localparam logic [7:0]  PES_PFX0  = 8'h00;
  localparam logic [7:0]  PES_PFX2  = 8'h01;
  localparam int unsigned TEI_BIT   = 7;
  localparam int unsigned PUSI_BIT  = 6;
  localparam int unsigned PCR_BIT   = 4;
  localparam int unsigned NUM_PID   = 32;
  localparam int unsigned NUM_KEY   = 16;
  localparam int unsigned NUM_KEYW  = 4 * NUM_KEY;
  localparam logic [7:0]  PWM_INIT  = 8'h00;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [9:0] ADDR_CTRL   = 10'h000;
  localparam logic [9:0] ADDR_STATUS = 10'h004;
  localparam logic [9:0] ADDR_PWM    = 10'h008;
  localparam logic [9:0] ADDR_STC    = 10'h00C;
  localparam logic [9:0] ADDR_LOSS   = 10'h010;
  localparam logic [9:0] ADDR_KEYRDY = 10'h014;
  localparam logic [2:0] PID_WIN     = 3'h1;  // 0x080..0x0FC
  localparam logic       KEY_WIN     = 1'b1;  // 0x200..0x3FC, 0x300..0x3FC alias 0x200..0x2FC, write only

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ROUTE_DROP = 2'h0, ROUTE_CPU = 2'h1, ROUTE_AV = 2'h2} route_t;
  typedef enum logic [1:0] {REC_OFF = 2'h0, REC_CLEAR = 2'h1, REC_MIXED = 2'h2, REC_SELECT = 2'h3} rec_mode_t;
  typedef enum logic [1:0] {DESC_AUTO = 2'h0, DESC_OFF = 2'h1, DESC_ON = 2'h2} desc_mode_t;

  typedef struct packed {
    logic [1:0] desc_mode;
    logic [1:0] rec_mode;
    logic       tei_en;
    logic       err_low;
    logic       start_low;
    logic       valid_low;
    logic       clk_fall;
    logic       rx_en;
  } ctrl_t;

  typedef struct packed {
    logic        accept;
    logic        encrypted;
    logic [3:0]  key_idx;
    logic [1:0]  buf_sel;
    logic [1:0]  route;
    logic        en;
    logic [12:0] pid;
  } pid_entry_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic       descramble;
    logic [1:0] buf_sel;
    logic [7:0] data;
  } beat_t;

  typedef struct packed {
    logic       byte_clk;
    logic       valid;
    logic       start;
    logic       err;
    logic [7:0] data;
  } link_t;

endpackage
`default_nettype wire

// File: verilog/packet_parser_input.sv
// Transport packet parser input: capture, PID filter, routing, loss, PCR latch, PWM
//
// Overview of operation
// - One byte is captured per active edge of the input byte clock.
// - Packet-start marks byte zero; a packet is 188 bytes from there.
// - Capturing edge of the byte clock is selectable; rising after reset.
// - Qualifier, start marker and error flag have own polarity, active high default.
// - Byte times with the qualifier inactive are ignored everywhere.
// - Error flag is sampled only at the third header byte.
// - Errored packet is discarded unless transport error enable is set.
// - While recording, errored packets go to recording port with error bit set.
// - All input is discarded until firmware sets reception enable.
// - Encrypted channel dropped until its key arrives or firmware accepts it.
// - PID compared against 32 entries; drop, CPU, or direct store chosen.
// - Pure audio/video payload packets go to their memory buffer by DMA.
// - Other wanted packets go to CPU queue with one fast interrupt each.
// - Missing packets are detected and reported for concealment.
// - A packet carrying a PCR latches the system clock counter for software.
// - Oscillator control is a PWM output with 256 software-set duty levels.
// - Transport or PES level scrambling is detected and routed to the descrambler.
// - Descrambler follows packet content or a processor command.
// - Sixteen key pairs, chosen per PID, shareable by several PIDs.
// - Bursts up to 72.8 Mbit/s and 60 Mbit/s sustained are taken without loss.
// - Back-to-back packets with no idle time are accepted.
// - Recording: clear full stream, full stream partly descrambled, or selected PIDs.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module packet_parser_input (
  // Clock and reset
  input  wire  logic               mclk_i,
  input  wire  logic               srst_i,
  // Front-end link
  input  wire  logic               input_byte_clock_i,
  input  wire  logic               byte_valid_qualifier_i,
  input  wire  logic               packet_start_i,
  input  wire  logic               input_error_flag_i,
  input  wire  logic [7:0]         parallel_stream_input_i,
  // Register port
  input  wire  logic [9:0]         reg_addr_i,
  input  wire  logic [31:0]        reg_wdata_i,
  input  wire  logic               reg_wr_i,
  input  wire  logic               reg_rd_i,
  output logic       [31:0]        reg_rdata_o,
  // Packet outputs
  output parser_pkg::beat_t        av_beat_o,
  output parser_pkg::beat_t        cpu_beat_o,
  output parser_pkg::beat_t        rec_beat_o,
  output logic                     fast_interrupt_o,
  // Descrambler control
  output logic                     desc_on_o,
  output logic                     desc_pes_o,
  output logic       [63:0]        desc_key_o,
  // Loss report and oscillator control
  output logic                     loss_o,
  output logic                     vcxo_pwm_o
);
  import parser_pkg::*;

  // ---------------------------------------------------------------------------
  // Link synchroniser and byte strobe
  // ---------------------------------------------------------------------------
  link_t s1_reg, s2_reg, s3_reg;
  logic  clk_lvl_reg;
  ctrl_t ctrl_reg;

  wire link_t raw_w = '{byte_clk: input_byte_clock_i, valid: byte_valid_qualifier_i,
                        start: packet_start_i, err: input_error_flag_i, data: parallel_stream_input_i};
  wire clk_agree_w = (s2_reg.byte_clk == s3_reg.byte_clk);
  wire clk_chg_w   = clk_agree_w && (s3_reg.byte_clk != clk_lvl_reg);
  wire byte_stb_w  = clk_chg_w && (s3_reg.byte_clk ^ ctrl_reg.clk_fall);
  wire valid_w     = s3_reg.valid ^ ctrl_reg.valid_low;
  wire start_w     = s3_reg.start ^ ctrl_reg.start_low;
  wire err_w       = s3_reg.err ^ ctrl_reg.err_low;
  wire acc_w       = byte_stb_w && valid_w && ctrl_reg.rx_en;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      s1_reg      <= '0;
      s2_reg      <= '0;
      s3_reg      <= '0;
      clk_lvl_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= raw_w;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (clk_agree_w)
        clk_lvl_reg <= s3_reg.byte_clk;
    end
  end

  // ---------------------------------------------------------------------------
  // Byte position and header capture
  // ---------------------------------------------------------------------------
  logic [7:0] pos_reg;
  logic [7:0] hdr_reg [4];
  logic [7:0] alen_reg;
  logic       err_reg;
  logic       pes_ok_reg;

  wire        open_w  = (pos_reg != 8'h00) && (pos_reg < 8'(PKT_LEN));
  wire        inpk_w  = start_w || open_w;
  wire [7:0]  idx_w   = start_w ? 8'h00 : pos_reg;
  wire        byte_w  = acc_w && inpk_w;
  wire [7:0]  din_w   = s3_reg.data;
  wire        trunc_w = acc_w && start_w && open_w;
  wire        dec_w   = byte_w && (idx_w == IDX_DEC);
  wire [12:0] pid_w   = {hdr_reg[1][4:0], hdr_reg[2]};
  wire [1:0]  afc_w   = din_w[5:4];
  wire [1:0]  scr_w   = din_w[7:6];

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      pos_reg <= 8'h00;
    else if (acc_w && inpk_w)
      pos_reg <= idx_w + 8'h01;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      err_reg    <= 1'b0;
      alen_reg   <= 8'h00;
      pes_ok_reg <= 1'b0;
      for (int i = 0; i < 4; i++)
        hdr_reg[i] <= 8'h00;
    end
    else if (byte_w)
    begin
      if (idx_w <= IDX_DEC)
        hdr_reg[idx_w[1:0]] <= din_w;
      if (idx_w == IDX_ERR)
        err_reg <= err_w;
      if (idx_w == IDX_ALEN)
        alen_reg <= din_w;
      if (idx_w >= IDX_PES0 && idx_w <= IDX_PES2)
        pes_ok_reg <= (idx_w == IDX_PES0 ? 1'b1 : pes_ok_reg) &&
                      (din_w == (idx_w == IDX_PES2 ? PES_PFX2 : PES_PFX0));
    end
  end

  // ---------------------------------------------------------------------------
  // PID table and key table
  // ---------------------------------------------------------------------------
  pid_entry_t  pid_tab [NUM_PID];
  logic [31:0] key_mem [NUM_KEYW];
  logic [15:0] key_rdy_reg;
  logic [31:0] hit_w;

  wire pid_wr_w = reg_wr_i && (reg_addr_i[9:7] == PID_WIN);
  wire key_wr_w = reg_wr_i && (reg_addr_i[9] == KEY_WIN);
  wire [4:0] pid_wi_w = reg_addr_i[6:2];
  wire [5:0] key_wi_w = reg_addr_i[7:2];

  generate
    for (genvar g = 0; g < NUM_PID; g++)
    begin : g_match
      assign hit_w[g] = pid_tab[g].en && (pid_tab[g].pid == pid_w);
    end
  endgenerate

  function automatic logic [4:0] first_hit(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_PID - 1; i >= 0; i--)
      if (v[i])
        r = 5'(i);
    return r;
  endfunction

  wire        any_hit_w = |hit_w;
  wire [4:0]  hidx_w    = first_hit(hit_w);
  pid_entry_t ent_w;
  assign ent_w = pid_tab[hidx_w];

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < NUM_PID; i++)
        pid_tab[i] <= '0;
    end
    else if (pid_wr_w)
      pid_tab[pid_wi_w] <= pid_entry_t'(reg_wdata_i[23:0]);
  end

  always_ff @(posedge mclk_i)
  begin
    if (key_wr_w)
      key_mem[key_wi_w] <= reg_wdata_i;
  end

  // Key write marks the pair ready; a write of one clears, a same-cycle key write wins
  wire wr_keyrdy_w = reg_wr_i && (reg_addr_i == ADDR_KEYRDY);
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      key_rdy_reg <= 16'h0000;
    else
    begin
      for (int k = 0; k < NUM_KEY; k++)
        if (key_wr_w && key_wi_w[5:2] == 4'(k))
          key_rdy_reg[k] <= 1'b1;
        else if (wr_keyrdy_w && reg_wdata_i[k])
          key_rdy_reg[k] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Packet decision at the last header byte
  // ---------------------------------------------------------------------------
  wire drop_err_w  = err_reg && !ctrl_reg.tei_en;
  wire locked_w    = ent_w.encrypted && !(key_rdy_reg[ent_w.key_idx] || ent_w.accept);
  wire want_w      = any_hit_w && !locked_w && !drop_err_w && (ent_w.route != ROUTE_DROP);
  wire av_w        = want_w && (ent_w.route == ROUTE_AV) && (afc_w == 2'b01);
  wire cpu_w       = want_w && !av_w;
  wire scr_hit_w   = any_hit_w && ent_w.encrypted && !locked_w;
  wire desc_w      = (ctrl_reg.desc_mode == DESC_ON) ||
                     ((ctrl_reg.desc_mode == DESC_AUTO) && (scr_w != 2'b00) && scr_hit_w);
  wire rec_all_w   = (ctrl_reg.rec_mode == REC_CLEAR) || (ctrl_reg.rec_mode == REC_MIXED);
  wire rec_w       = rec_all_w || ((ctrl_reg.rec_mode == REC_SELECT) && scr_hit_w);
  wire rec_desc_w  = (ctrl_reg.rec_mode != REC_CLEAR) && desc_w;
  wire [5:0] kw_w  = {ent_w.key_idx, scr_w[0], 1'b0};

  logic       to_av_reg, to_cpu_reg, to_rec_reg, rec_desc_reg, pcr_chk_reg;
  logic [1:0] buf_reg;
  logic [2:0] rep_reg;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      to_av_reg    <= 1'b0;
      to_cpu_reg   <= 1'b0;
      to_rec_reg   <= 1'b0;
      rec_desc_reg <= 1'b0;
      desc_on_o    <= 1'b0;
      buf_reg      <= 2'h0;
      desc_key_o   <= 64'h0;
      pcr_chk_reg  <= 1'b0;
    end
    else if (dec_w)
    begin
      to_av_reg    <= av_w;
      to_cpu_reg   <= cpu_w;
      to_rec_reg   <= rec_w;
      rec_desc_reg <= rec_desc_w;
      desc_on_o    <= desc_w;
      buf_reg      <= ent_w.buf_sel;
      desc_key_o   <= {key_mem[kw_w | 6'h01], key_mem[kw_w]};
      pcr_chk_reg  <= afc_w[1];
    end
    else if (trunc_w)
    begin
      to_av_reg  <= 1'b0;
      to_cpu_reg <= 1'b0;
      to_rec_reg <= 1'b0;
    end
  end

  // PES level scrambling seen at the PES flags byte of a unit start
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      desc_pes_o <= 1'b0;
    else if (dec_w)
      desc_pes_o <= 1'b0;
    else if (byte_w && idx_w == IDX_PSCR && hdr_reg[1][PUSI_BIT] && hdr_reg[3][5:4] == 2'b01 && pes_ok_reg)
      desc_pes_o <= (din_w[5:4] != 2'b00);
  end

  // ---------------------------------------------------------------------------
  // Output beats: header replayed after the decision, then bytes as they come
  // ---------------------------------------------------------------------------
  wire        rep_w   = (rep_reg != 3'h0);
  wire        emit_w  = rep_w || (byte_w && idx_w > IDX_DEC);
  wire [7:0]  hbyte_w = hdr_reg[2'(rep_reg - 3'h1)];
  wire [7:0]  ebyte_w = rep_w ? hbyte_w : din_w;
  wire        efirst_w = (rep_reg == 3'h1);
  wire        elast_w  = !rep_w && (idx_w == POS_LAST);
  wire [7:0]  rbyte_w  = (rep_reg == 3'h2 && err_reg) ? (ebyte_w | 8'(1 << TEI_BIT)) : ebyte_w;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      rep_reg <= 3'h0;
    else if (dec_w)
      rep_reg <= 3'h1;
    else if (rep_w)
      rep_reg <= (rep_reg == 3'h4) ? 3'h0 : rep_reg + 3'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      av_beat_o        <= '0;
      cpu_beat_o       <= '0;
      rec_beat_o       <= '0;
      fast_interrupt_o <= 1'b0;
    end
    else
    begin
      av_beat_o  <= '{valid: emit_w && to_av_reg, first: efirst_w, last: elast_w,
                      descramble: desc_on_o, buf_sel: buf_reg, data: ebyte_w};
      cpu_beat_o <= '{valid: emit_w && to_cpu_reg, first: efirst_w, last: elast_w,
                      descramble: desc_on_o, buf_sel: 2'h0, data: ebyte_w};
      rec_beat_o <= '{valid: emit_w && to_rec_reg, first: efirst_w, last: elast_w,
                      descramble: rec_desc_reg, buf_sel: 2'h0, data: rbyte_w};
      fast_interrupt_o <= emit_w && to_cpu_reg && elast_w;
    end
  end

  // ---------------------------------------------------------------------------
  // Continuity check per PID entry
  // ---------------------------------------------------------------------------
  logic [3:0]  cc_mem [NUM_PID];
  logic [31:0] seen_reg;
  logic [15:0] loss_cnt_reg;
  logic [4:0]  loss_idx_reg;
  logic        loss_st_reg;

  wire [3:0] cc_w     = din_w[3:0];
  wire [3:0] cc_old_w = cc_mem[hidx_w];
  wire       cc_bad_w = dec_w && any_hit_w && afc_w[0] && seen_reg[hidx_w] &&
                        (cc_w != cc_old_w + 4'h1) && (cc_w != cc_old_w);
  wire       lost_w   = cc_bad_w || trunc_w;
  wire       wr_st_w  = reg_wr_i && (reg_addr_i == ADDR_STATUS);

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      seen_reg     <= 32'h0;
      loss_cnt_reg <= 16'h0;
      loss_idx_reg <= 5'h0;
      loss_o       <= 1'b0;
      for (int i = 0; i < NUM_PID; i++)
        cc_mem[i] <= 4'h0;
    end
    else
    begin
      loss_o <= lost_w;
      if (pid_wr_w)
        seen_reg[pid_wi_w] <= 1'b0;
      else if (dec_w && any_hit_w && afc_w[0])
      begin
        seen_reg[hidx_w] <= 1'b1;
        cc_mem[hidx_w]   <= cc_w;
      end
      if (lost_w)
      begin
        loss_cnt_reg <= loss_cnt_reg + 16'h1;
        loss_idx_reg <= hidx_w;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      loss_st_reg <= 1'b0;
    else if (lost_w)
      loss_st_reg <= 1'b1;
    else if (wr_st_w && reg_wdata_i[1])
      loss_st_reg <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // System clock latch on PCR
  // ---------------------------------------------------------------------------
  logic [31:0] stc_reg, stc_lat_reg;
  logic        pcr_st_reg;

  wire pcr_w = byte_w && (idx_w == IDX_AFLG) && pcr_chk_reg && (alen_reg != 8'h00) && din_w[PCR_BIT];

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      stc_reg     <= 32'h0;
      stc_lat_reg <= 32'h0;
      pcr_st_reg  <= 1'b0;
    end
    else
    begin
      stc_reg <= stc_reg + 32'h1;
      if (pcr_w)
        stc_lat_reg <= stc_reg;
      if (pcr_w)
        pcr_st_reg <= 1'b1;
      else if (wr_st_w && reg_wdata_i[0])
        pcr_st_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Oscillator PWM
  // ---------------------------------------------------------------------------
  logic [7:0] pwm_cnt_reg, duty_reg;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      pwm_cnt_reg <= 8'h00;
      vcxo_pwm_o  <= 1'b0;
    end
    else
    begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      vcxo_pwm_o  <= (pwm_cnt_reg < duty_reg);
    end
  end

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  wire [31:0] status_w = {29'h0, desc_pes_o, loss_st_reg, pcr_st_reg};
  wire [31:0] rd_mux_w =
      (reg_addr_i == ADDR_CTRL)           ? 32'(ctrl_reg) :
      (reg_addr_i == ADDR_STATUS)         ? status_w :
      (reg_addr_i == ADDR_PWM)            ? {24'h0, duty_reg} :
      (reg_addr_i == ADDR_STC)            ? stc_lat_reg :
      (reg_addr_i == ADDR_LOSS)           ? {11'h0, loss_idx_reg, loss_cnt_reg} :
      (reg_addr_i == ADDR_KEYRDY)         ? {16'h0, key_rdy_reg} :
      (reg_addr_i[9:7] == PID_WIN)        ? 32'(pid_tab[pid_wi_w]) : 32'h0;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ctrl_reg    <= '0;
      duty_reg    <= PWM_INIT;
      reg_rdata_o <= 32'h0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == ADDR_CTRL)
        ctrl_reg <= ctrl_t'(reg_wdata_i[9:0]);
      if (reg_wr_i && reg_addr_i == ADDR_PWM)
        duty_reg <= reg_wdata_i[7:0];
      reg_rdata_o <= reg_rd_i ? rd_mux_w : 32'h0;
    end
  end

endmodule // packet_parser_input
`default_nettype wire

// File: tb/tpp_in_chk.sv
// Port checker for the transport packet parser input
`timescale 1ns/1ns
`default_nettype none
module parser_chk (
  // Clock and reset
  input wire logic              mclk_i,
  input wire logic              srst_i,
  // Register port
  input wire logic [9:0]        reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_rdata_o,
  // Outputs
  input wire parser_pkg::beat_t av_beat_o,
  input wire parser_pkg::beat_t cpu_beat_o,
  input wire logic              fast_interrupt_o,
  input wire logic              loss_o,
  input wire logic              vcxo_pwm_o
);
  import parser_pkg::*;
  logic       rx_seen;
  logic [7:0] duty;
  int         zero_run;
  int         av_idx;
  wire logic  ctrl_wr = reg_wr_i && reg_addr_i == ADDR_CTRL;
  wire logic  pwm_wr  = reg_wr_i && reg_addr_i == ADDR_PWM;
  always_ff @(posedge mclk_i)
  begin
    rx_seen  <= !srst_i && (rx_seen || (ctrl_wr && reg_wdata_i[0]));
    duty     <= srst_i ? PWM_INIT : pwm_wr ? reg_wdata_i[7:0] : duty;
    zero_run <= (srst_i || duty != 8'h00) ? 0 : zero_run + int'(zero_run < 300);
    av_idx   <= srst_i ? 0 : !av_beat_o.valid ? av_idx : av_beat_o.first ? 1 : av_idx + 1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // ----------
  // Assertions
  // ----------
  reset_quiet_a: assert property (disable iff (1'b0) srst_i |=> !av_beat_o.valid && !fast_interrupt_o)
    else $error("output active after reset");
  rx_gate_a: assert property (!rx_seen |-> !av_beat_o.valid && !cpu_beat_o.valid)
    else $error("beat before reception enabled");
  irq_last_a: assert property (fast_interrupt_o |-> cpu_beat_o.valid && cpu_beat_o.last)
    else $error("interrupt apart from last cpu beat");
  irq_pulse_a: assert property (fast_interrupt_o |=> !fast_interrupt_o)
    else $error("interrupt longer than one cycle");
  loss_pulse_a: assert property ($rose(loss_o) |=> $fell(loss_o))
    else $error("loss report longer than one cycle");
  av_length_a: assert property (av_beat_o.valid && av_beat_o.last |-> av_idx == 187)
    else $error("av packet length wrong");
  key_hidden_a: assert property ($past(reg_rd_i && reg_addr_i[9:8] == 2'h2) |-> reg_rdata_o == 32'h0)
    else $error("key table readable");
  duty_read_a: assert property ($past(reg_rd_i && reg_addr_i == ADDR_PWM) |-> reg_rdata_o[7:0] == duty)
    else $error("duty read back wrong");
  pwm_zero_a: assert property (zero_run >= 258 |-> !vcxo_pwm_o)
    else $error("pwm high at zero duty");
  cover property (av_beat_o.valid && av_beat_o.last);
  cover property (fast_interrupt_o);
  cover property (loss_o);
endmodule // parser_chk
`default_nettype wire

// File: tb/front_end_model.sv
// Front-end model driving transport packets onto the byte link
`timescale 1ns/1ns
`default_nettype none
module front_end_model (
  // Link inversion: edge, valid, start, error
  input  wire logic [3:0]        inv_i,
  // Byte link toward the parser
  output var parser_pkg::link_t  link_o
);
  import parser_pkg::*;
  initial link_o = '0;
  // ----------
  // Byte slots
  // ----------
  task automatic slot(input logic [7:0] d, input logic v, input logic s, input logic e);
    link_o.byte_clk <= inv_i[0];
    link_o.data <= d;
    link_o.valid <= v ^ inv_i[1];
    link_o.start <= s ^ inv_i[2];
    link_o.err <= e ^ inv_i[3];
    #80 link_o.byte_clk <= ~inv_i[0];
    #80;
  endtask
  // Clock stands still, data no longer held
  task automatic idle();
    link_o.data <= ~link_o.data;
    link_o.valid <= inv_i[1];
    link_o.start <= inv_i[2];
    link_o.err <= inv_i[3];
    link_o.byte_clk <= inv_i[0];
  endtask
  task automatic send(input logic [12:0] p, input logic [3:0] cc, input logic err, input logic gaps,
                      input logic [31:0] f);
    for (int i = 0; i < PKT_LEN; i++)
    begin
      if (gaps && f[i % 32]) slot(~f[7:0], 1'b0, 1'b0, 1'b0);
      slot(i == 0 ? 8'h47 : i == 1 ? {3'h0, p[12:8]} : i == 2 ? p[7:0] : i == 3 ? {4'h1, cc} : f[7:0] ^ 8'(i),
           1'b1, i == 0, (i == 2) == err);
    end
  endtask
endmodule // front_end_model
`default_nettype wire

// File: tb/packet_parser_input_test.sv
// Self-checking bench for the transport packet parser input
`timescale 1ns/1ns
`default_nettype none
module packet_parser_input_test;
  import parser_pkg::*;
  logic        mclk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [9:0]  reg_addr_i = 10'h000;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  beat_t       av_beat_o, cpu_beat_o, rec_beat_o;
  logic        fast_interrupt_o, loss_o, vcxo_pwm_o, rec_pf, rx = 1'b0, keyed = 1'b0, rec = 1'b0;
  link_t       link;
  logic [3:0]  inv = 4'h0;
  logic [3:0]  cc [5] = '{default: 4'h0};
  logic [7:0]  rec_b1, d;
  int          bad_count = 0, cmp_count = 0, seed = 36, av_n = 0, cpu_n = 0, rec_n = 0, irq_n = 0, loss_n = 0, h, e;
  packet_parser_input dut_u (.mclk_i, .srst_i, .input_byte_clock_i(link.byte_clk), .byte_valid_qualifier_i(link.valid),
    .packet_start_i(link.start), .input_error_flag_i(link.err), .parallel_stream_input_i(link.data), .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .av_beat_o, .cpu_beat_o, .rec_beat_o, .fast_interrupt_o,
    .desc_on_o(), .desc_pes_o(), .desc_key_o(), .loss_o, .vcxo_pwm_o);
  front_end_model fe_u (.inv_i(inv), .link_o(link));
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    av_n <= av_n + int'(av_beat_o.valid);
    cpu_n <= cpu_n + int'(cpu_beat_o.valid);
    rec_n <= rec_n + int'(rec_beat_o.valid);
    irq_n <= irq_n + int'(fast_interrupt_o);
    loss_n <= loss_n + int'(loss_o);
    if (rec_beat_o.valid) rec_pf <= rec_beat_o.first;
    if (rec_beat_o.valid && rec_pf) rec_b1 <= rec_beat_o.data;
  end
  // -----------
  // Bench tasks
  // -----------
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] x);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    check("register", reg_rdata_o, x);
  endtask
  function automatic logic [31:0] ent(input int k);
    return {9'h0, k == 3, 4'h0, k == 0 ? 2'h1 : 2'h0, k == 0 ? ROUTE_AV : k == 2 ? ROUTE_DROP : ROUTE_CPU, 1'b1,
            13'h100 + 13'(k)};
  endfunction
  function automatic int beats(input int path, input int k, input logic err);
    if (!rx) return 0;
    if (path == 2) return rec ? PKT_LEN : 0;
    if (err) return 0;
    return (path == 0 && k == 0) || (path == 1 && (k == 1 || (k == 3 && keyed))) ? PKT_LEN : 0;
  endfunction
  task automatic run(input int k, input logic err, input logic gaps, input int n);
    int a, c, r, q;
    a = av_n;
    c = cpu_n;
    r = rec_n;
    q = irq_n;
    repeat (n)
    begin
      fe_u.send(13'h100 + 13'(k), cc[k], err, gaps, $random(seed));
      cc[k]++;
    end
    fe_u.idle();
    repeat (40) @(posedge mclk_i);
    check("av beats", av_n - a, n * beats(0, k, err));
    check("cpu beats", cpu_n - c, n * beats(1, k, err));
    check("fast irq", irq_n - q, n * beats(1, k, err) / PKT_LEN);
    check("rec beats", rec_n - r, n * beats(2, k, err));
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // -------------
  // Main sequence
  // -------------
  initial
  begin
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    rd(ADDR_CTRL, 32'h0);
    for (e = 0; e < 4; e++) wr(10'h080 + 10'(4 * e), ent(e));
    run(0, 1'b0, 1'b0, 1);
    rx = 1'b1;
    wr(ADDR_CTRL, 32'h1);
    repeat (6) run({$random(seed)} % 5, 1'($random(seed)), 1'b1, 1);
    h = loss_n;
    cc[0] = 4'h5;
    wr(10'h080, ent(0));
    run(0, 1'b0, 1'b0, 1);
    cc[0] = 4'h7;
    run(0, 1'b0, 1'b0, 1);
    check("loss", loss_n - h, 1);
    rd(ADDR_LOSS, 32'h1);
    rd(ADDR_STATUS, 32'h2);
    run(0, 1'b0, 1'b0, 2);
    wr(ADDR_CTRL, 32'h1F);
    inv <= 4'hF;
    @(posedge mclk_i);
    run(1, 1'b0, 1'b1, 1);
    run(1, 1'b1, 1'b0, 1);
    wr(ADDR_CTRL, 32'h41);
    inv <= 4'h0;
    rec = 1'b1;
    @(posedge mclk_i);
    run(1, 1'b1, 1'b0, 1);
    check("rec header", rec_b1, 8'h81);
    run(1, 1'b0, 1'b0, 1);
    check("rec header", rec_b1, 8'h01);
    rec = 1'b0;
    wr(ADDR_CTRL, 32'h1);
    run(3, 1'b0, 1'b0, 1);
    wr(10'h200, $random(seed));
    keyed = 1'b1;
    rd(ADDR_KEYRDY, 32'h1);
    rd(10'h200, 32'h0);
    run(3, 1'b0, 1'b0, 1);
    for (e = 0; e < 2; e++)
    begin
      d = e ? 8'($random(seed)) : 8'hFF;
      wr(ADDR_PWM, {24'h0, d});
      rd(ADDR_PWM, {24'h0, d});
      repeat (512) @(posedge mclk_i);
      h = 0;
      repeat (256) @(posedge mclk_i) h += int'(vcxo_pwm_o);
      check("pwm high", h, d);
    end
    end_of_test();
  end
  initial
  begin
    #800000;
    bad_count++;
    end_of_test();
  end
endmodule // packet_parser_input_test
bind packet_parser_input parser_chk chk_u (.mclk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .av_beat_o, .cpu_beat_o, .fast_interrupt_o, .loss_o, .vcxo_pwm_o);
`default_nettype wire
